/* logic/dmc_defines.svh */
// register offsets, field positions, reset values and timing constants of the monitor config
`ifndef DMC_DEFINES_SVH
`define DMC_DEFINES_SVH

`define DMC_ADDR_W            7
`define DMC_CFG_ADDR          7'h40
`define DMC_STEP15_ADDR       7'h1F
`define DMC_CFG_RESET         16'h0000
`define DMC_CFG_WMASK         16'hF107
`define DMC_BIT_MAP_CHECK     15
`define DMC_BIT_POLY_SEL      14
`define DMC_BIT_CLK_COUNT     13
`define DMC_BIT_TIMEOUT       12
`define DMC_BIT_FAULT_OUTPUT_POLARITY     8
`define DMC_BIT_LOSS_POL      2
`define DMC_FLD_WIN_HI        1
`define DMC_FLD_WIN_LO        0
`define DMC_MAP_SECT_LO       7'h40
`define DMC_MAP_SECT_HI       7'h59
`define DMC_STAT_FAULT_HI     14
`define DMC_STAT_FAULT_LO     7
`define DMC_TIMEOUT_EXP       14
`define DMC_WIN_OFF           2'h0
`define DMC_WIN_SHORT         2'h1
`define DMC_WIN_MID           2'h2
`define DMC_WIN_LONG          2'h3
`define DMC_WIN_SHORT_TICKS   15'h1400
`define DMC_WIN_MID_TICKS     15'h2800
`define DMC_WIN_LONG_TICKS    15'h5000
`define DMC_WIN_TICK_W        15
`define DMC_GPIO_SRC_FAULT    1'h1
`define DMC_FMT_PUSH_PULL     1'h0

`endif

/* logic/dmc_monitor_config.sv */
// device monitor configuration register, frame timeout, host-loss watchdog and fault pins
//
// Function
// - step15 result is read-only 16-bit two's complement
// - bit15 enables check over 40h..59h
// - poly select: 0 CCITT, 1 ANSI
// - bit13 turns serial clock counter on/off
// - bit12 timeout after 2^14 oscillator periods
// - after timeout discard inputs until chip-select rises
// - new transaction only at next chip-select fall
// - bits 11:9 reserved, read zero
// - bit8 sets fault output polarity
// - fault when unmasked status bits 14:7 active
// - fault reaches pin via source select, format
// - config at 40h, resets to zero
// - window field selects off/5120/10240/20480 periods
// - watchdog restarts on valid CRC command
// - bit2 sets host-loss output polarity
`include "dmc_defines.svh"
module dmc_monitor_config
    import dmc_pkg::*;
#(
    parameter int TIMEOUT_EXP = `DMC_TIMEOUT_EXP
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        osc_tick_i,         // one pulse per internal_osc_period
    input  wire logic        chip_sel_n_i,       // serial chip select pin, asynchronous
    input  wire logic        serial_bit_valid_i, // decoder saw a serial input bit
    input  wire logic        cmd_crc_ok_i,       // pulse: valid command with good CRC
    input  wire dmc_req_type req_i,              // register access from decoder
    input  wire logic [15:0] step15_result_value_i,
    input  wire logic [15:0] status_i,
    input  wire logic [15:0] status_mask_i,      // 1 masks the status bit
    input  wire logic        pin_two_source_select_i,
    input  wire logic        pin_two_drive_format_i,
    input  wire logic        pin_zero_source_select_i,
    output logic [15:0]      rdata_o,
    output logic             rvalid_o,
    output dmc_cfg_type      cfg_o,
    output logic             map_check_addr_o,   // request address lies in the checked section
    output logic             serial_bit_accept_o,
    output logic             frame_timeout_o,
    output logic             pin_two_o,
    output logic             pin_two_oe_o,
    output logic             host_loss_output_o,
    output logic             host_loss_oe_o
);

    // elaboration check: the frame counter width must stay within a plain int shift
    if (TIMEOUT_EXP < 2 || TIMEOUT_EXP > 30) begin : g_exp_check
        $error("dmc: TIMEOUT_EXP out of range");
    end

    // ---------------- configuration register ----------------
    logic [15:0] cfg_q;          // stored writable bits only
    logic [15:0] cfg_d;
    logic [15:0] rdata_q;        // read data register
    logic [15:0] rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;

    // write decode and read mux
    always_comb begin
        cfg_d    = cfg_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        if (req_i.wr && req_i.addr == `DMC_CFG_ADDR) begin
            cfg_d = req_i.wdata & `DMC_CFG_WMASK;
        end
        if (req_i.rd) begin
            rvalid_d = 1'b1;
            case (req_i.addr)
                `DMC_CFG_ADDR:    rdata_d = cfg_q & `DMC_CFG_WMASK;
                `DMC_STEP15_ADDR: rdata_d = step15_result_value_i;
                default:          rdata_d = 16'h0000;
            endcase
        end
    end

    // register stage; reset leaves every function disabled
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cfg_q    <= `DMC_CFG_RESET;
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            cfg_q    <= cfg_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign rdata_o  = rdata_q;
    assign rvalid_o = rvalid_q;

    // decoded fields drive the crc engines and counters outside
    assign cfg_o.map_section_check_enable = cfg_q[`DMC_BIT_MAP_CHECK];
    assign cfg_o.poly_select              = cfg_q[`DMC_BIT_POLY_SEL];
    assign cfg_o.clock_count_enable       = cfg_q[`DMC_BIT_CLK_COUNT];
    assign cfg_o.timeout_enable           = cfg_q[`DMC_BIT_TIMEOUT];
    assign cfg_o.fault_output_polarity    = cfg_q[`DMC_BIT_FAULT_OUTPUT_POLARITY];
    assign cfg_o.host_loss_polarity       = cfg_q[`DMC_BIT_LOSS_POL];
    assign cfg_o.host_loss_window_select  = cfg_q[`DMC_FLD_WIN_HI:`DMC_FLD_WIN_LO];

    // section membership, qualified by enable so the crc engine sees one flag
    assign map_check_addr_o = cfg_q[`DMC_BIT_MAP_CHECK]
                              && req_i.addr >= `DMC_MAP_SECT_LO
                              && req_i.addr <= `DMC_MAP_SECT_HI;

    // ---------------- chip select synchroniser ----------------
    logic cs_meta_q;             // first stage, read only by cs_sync_q
    logic cs_sync_q;
    logic cs_last_q;             // for edge detection

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            cs_last_q <= 1'b1;
        end else begin
            cs_meta_q <= chip_sel_n_i;
            cs_sync_q <= cs_meta_q;
            cs_last_q <= cs_sync_q;
        end
    end

    logic cs_fall;
    logic cs_rise;
    assign cs_fall = cs_last_q && !cs_sync_q;
    assign cs_rise = !cs_last_q && cs_sync_q;

    // ---------------- frame timeout ----------------
    localparam int TO_W = TIMEOUT_EXP + 1;
    localparam logic [TO_W-1:0] TO_LIMIT = TO_W'(1) << TIMEOUT_EXP;
    logic          to_expired;
    dmc_frame_type frame_q;
    dmc_frame_type frame_d;

    dmc_tick_timer #(
        .WIDTH (TO_W)
    ) u_frame_timer (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (frame_q == DMC_ACTIVE && cfg_q[`DMC_BIT_TIMEOUT]),
        .restart_i (cs_fall),
        .tick_i    (osc_tick_i),
        .limit_i   (TO_LIMIT),
        .expired_o (to_expired)
    );

    // frame sequencing; discard holds until chip select rises
    always_comb begin
        frame_d = frame_q;
        case (frame_q)
            DMC_IDLE: begin
                if (cs_fall) frame_d = DMC_ACTIVE;
            end
            DMC_ACTIVE: begin
                if (cs_rise) frame_d = DMC_IDLE;
                else if (to_expired) frame_d = DMC_DISCARD;
            end
            DMC_DISCARD: begin
                if (cs_rise) frame_d = DMC_IDLE;
            end
            default: frame_d = DMC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) frame_q <= DMC_IDLE;
        else          frame_q <= frame_d;
    end

    // input bits pass only inside a live frame
    assign serial_bit_accept_o = serial_bit_valid_i && frame_q == DMC_ACTIVE;
    assign frame_timeout_o     = frame_q == DMC_DISCARD;

    // ---------------- host-loss watchdog ----------------
    logic [`DMC_WIN_TICK_W-1:0] win_ticks;  // window length in oscillator ticks
    logic                       win_change; // window field changes value this cycle
    logic        wd_expired;
    logic        loss_q;         // latched until window field is cleared
    logic        loss_d;

    // a window field that changes value starts a fresh count so the old length never leaks over
    assign win_change = cfg_d[`DMC_FLD_WIN_HI:`DMC_FLD_WIN_LO]
                        != cfg_q[`DMC_FLD_WIN_HI:`DMC_FLD_WIN_LO];

    always_comb begin
        case (cfg_q[`DMC_FLD_WIN_HI:`DMC_FLD_WIN_LO])
            `DMC_WIN_SHORT: win_ticks = `DMC_WIN_SHORT_TICKS;
            `DMC_WIN_MID:   win_ticks = `DMC_WIN_MID_TICKS;
            `DMC_WIN_LONG:  win_ticks = `DMC_WIN_LONG_TICKS;
            default:        win_ticks = `DMC_WIN_SHORT_TICKS;
        endcase
    end

    // a command restarts the window; a window change restarts it too
    dmc_tick_timer #(
        .WIDTH (`DMC_WIN_TICK_W)
    ) u_host_timer (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (cfg_q[`DMC_FLD_WIN_HI:`DMC_FLD_WIN_LO] != `DMC_WIN_OFF),
        .restart_i (cmd_crc_ok_i || win_change),
        .tick_i    (osc_tick_i),
        .limit_i   (win_ticks),
        .expired_o (wd_expired)
    );

    // sticky loss flag; only disabling the watchdog releases it
    always_comb begin
        loss_d = loss_q;
        if (cfg_q[`DMC_FLD_WIN_HI:`DMC_FLD_WIN_LO] == `DMC_WIN_OFF) begin
            loss_d = 1'b0;
        end else if (wd_expired) begin
            loss_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) loss_q <= 1'b0;
        else          loss_q <= loss_d;
    end

    // ---------------- output pins ----------------
    logic fault_now;
    logic pin_two_q;
    logic pin_two_d;
    logic pin_two_oe_q;
    logic pin_two_oe_d;
    logic loss_pin_q;
    logic loss_pin_d;
    logic loss_oe_q;
    logic loss_oe_d;

    assign fault_now = |(status_i[`DMC_STAT_FAULT_HI:`DMC_STAT_FAULT_LO]
                        & ~status_mask_i[`DMC_STAT_FAULT_HI:`DMC_STAT_FAULT_LO]);

    // open-drain format drives only the low level, whichever polarity is set, else releases
    always_comb begin
        pin_two_d    = fault_now ~^ cfg_q[`DMC_BIT_FAULT_OUTPUT_POLARITY];
        pin_two_oe_d = pin_two_source_select_i == `DMC_GPIO_SRC_FAULT
                       && (pin_two_drive_format_i == `DMC_FMT_PUSH_PULL || !pin_two_d);
        loss_pin_d   = loss_q ~^ cfg_q[`DMC_BIT_LOSS_POL];
        loss_oe_d    = pin_zero_source_select_i == `DMC_GPIO_SRC_FAULT;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pin_two_q    <= 1'b1;
            pin_two_oe_q <= 1'b0;
            loss_pin_q   <= 1'b1;
            loss_oe_q    <= 1'b0;
        end else begin
            pin_two_q    <= pin_two_d;
            pin_two_oe_q <= pin_two_oe_d;
            loss_pin_q   <= loss_pin_d;
            loss_oe_q    <= loss_oe_d;
        end
    end

    assign pin_two_o          = pin_two_q;
    assign pin_two_oe_o       = pin_two_oe_q;
    assign host_loss_output_o = loss_pin_q;
    assign host_loss_oe_o     = loss_oe_q;

endmodule

/* logic/dmc_pkg.sv */
// types shared by the device monitor configuration block
package dmc_pkg;

    // decoded view of the monitor configuration word
    typedef struct packed {
        logic       map_section_check_enable;
        logic       poly_select;
        logic       clock_count_enable;
        logic       timeout_enable;
        logic       fault_output_polarity;
        logic       host_loss_polarity;
        logic [1:0] host_loss_window_select;
    } dmc_cfg_type;

    // register write/read request from the serial command decoder
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } dmc_req_type;

    // serial frame state
    typedef enum logic [1:0] {
        DMC_IDLE,
        DMC_ACTIVE,
        DMC_DISCARD
    } dmc_frame_type;

endpackage

/* logic/dmc_tick_timer.sv */
// oscillator-tick counter with enable, restart and terminal-count flag
module dmc_tick_timer
    import dmc_pkg::*;
#(
    parameter int WIDTH = 15
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             run_i,
    input  wire logic             restart_i,
    input  wire logic             tick_i,
    input  wire logic [WIDTH-1:0] limit_i,
    output logic                  expired_o
);

    // elaboration check: a one-bit counter cannot hold any useful limit
    if (WIDTH < 2) begin : g_width_check
        $error("dmc_tick_timer: WIDTH too small");
    end

    logic [WIDTH-1:0] count_q;   // ticks seen since restart
    logic [WIDTH-1:0] count_d;
    logic             exp_q;     // sticky until restart or stop
    logic             exp_d;

    // next count: restart wins, saturate once expired
    always_comb begin
        count_d = count_q;
        exp_d   = exp_q;
        if (restart_i || !run_i) begin
            count_d = '0;
            exp_d   = 1'b0;
        end else if (tick_i && !exp_q) begin
            if (count_q + WIDTH'(1) >= limit_i) begin
                exp_d = 1'b1;
            end
            count_d = count_q + WIDTH'(1);
        end
    end

    // registers only
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            count_q <= '0;
            exp_q   <= 1'b0;
        end else begin
            count_q <= count_d;
            exp_q   <= exp_d;
        end
    end

    assign expired_o = exp_q;

endmodule

/* tb/dmc_checker.sv */
// port-level assertions for the monitor configuration block
module dmc_checker
    import dmc_pkg::*;
#(
    parameter int TIMEOUT_EXP = 14
) (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic        osc_tick_i,
    input wire logic        chip_sel_n_i,
    input wire logic        serial_bit_valid_i,
    input wire logic        cmd_crc_ok_i,
    input wire dmc_req_type req_i,
    input wire logic [15:0] step15_result_value_i,
    input wire logic [15:0] status_i,
    input wire logic [15:0] status_mask_i,
    input wire logic        pin_two_source_select_i,
    input wire logic        pin_two_drive_format_i,
    input wire logic        pin_zero_source_select_i,
    input wire logic [15:0] rdata_o,
    input wire logic        rvalid_o,
    input wire dmc_cfg_type cfg_o,
    input wire logic        map_check_addr_o,
    input wire logic        serial_bit_accept_o,
    input wire logic        frame_timeout_o,
    input wire logic        pin_two_o,
    input wire logic        pin_two_oe_o,
    input wire logic        host_loss_output_o,
    input wire logic        host_loss_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic        fault_w; // unmasked status bit 14:7 active
    logic        level_w; // expected fault pin level
    logic        push_w;  // fault routed, push-pull
    logic        drain_w; // fault routed, open drain
    logic [15:0] word_w;  // config as it must read back
    assign fault_w = |(status_i[14:7] & ~status_mask_i[14:7]);
    assign level_w = fault_w ~^ cfg_o.fault_output_polarity;
    assign push_w = pin_two_source_select_i & ~pin_two_drive_format_i;
    assign drain_w = pin_two_source_select_i & pin_two_drive_format_i;
    assign word_w = {cfg_o[7:4], 3'h0, cfg_o[3], 5'h00, cfg_o[2:0]};
    // write to the config address
    sequence cfg_wr_s;
        req_i.wr && req_i.addr == 7'h40;
    endsequence
    // window cleared while the host-loss pin is routed
    sequence release_s;
        cfg_wr_s ##0 (req_i.wdata[1:0] == 2'h0 && pin_zero_source_select_i);
    endsequence
    cfg_reset_a: assert property ($rose(rst_n_i) |-> cfg_o == 8'h00)
        else $error("config not zero after reset");
    cfg_write_a: assert property (cfg_wr_s |=>
        cfg_o == {$past(req_i.wdata[15:12]), $past(req_i.wdata[8]), $past(req_i.wdata[2:0])})
        else $error("config write wrong");
    cfg_read_a: assert property (rvalid_o && $past(req_i.addr) == 7'h40 |->
        rdata_o == $past(word_w))
        else $error("config read wrong");
    step15_read_a: assert property (req_i.rd && req_i.addr == 7'h1F |=>
        rvalid_o && rdata_o == $past(step15_result_value_i))
        else $error("step15 read wrong");
    read_pulse_a: assert property (rvalid_o == $past(req_i.rd))
        else $error("read valid wrong");
    map_check_a: assert property (map_check_addr_o ==
        (cfg_o.map_section_check_enable && req_i.addr >= 7'h40 && req_i.addr <= 7'h59))
        else $error("map section flag wrong");
    discard_gate_a: assert property (serial_bit_accept_o |->
        serial_bit_valid_i && !frame_timeout_o)
        else $error("bit accepted while discarding");
    timeout_cause_a: assert property ($rose(frame_timeout_o) |->
        $past(cfg_o.timeout_enable))
        else $error("timeout while disabled");
    fault_pin_a: assert property ($past(push_w) && $past(rst_n_i) |->
        pin_two_oe_o && pin_two_o == $past(level_w))
        else $error("fault pin wrong");
    open_drain_a: assert property ($past(drain_w) && $past(rst_n_i) |->
        pin_two_oe_o == !$past(level_w))
        else $error("open drain enable wrong");
    host_release_a: assert property (release_s |-> ##3
        host_loss_output_o == !$past(cfg_o.host_loss_polarity))
        else $error("host-loss pin not released");
endmodule

bind dmc_monitor_config dmc_checker #(.TIMEOUT_EXP(TIMEOUT_EXP)) chk_u (.*);

/* tb/dmc_host_model.sv */
// host side of the serial link: frames of a given length ending in a good command
module dmc_host_model (
    input  wire logic        sys_clk_i,
    input  wire logic        start_i, // begin one frame
    input  wire logic [15:0] len_i,   // one less than the cycles with chip select low
    output logic             chip_sel_n_o,
    output logic             bit_valid_o,
    output logic             crc_ok_o,
    output logic             busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_q; // cycles left in the frame
    initial begin
        chip_sel_n_o = 1'b1;
        bit_valid_o = 1'b0;
        crc_ok_o = 1'b0;
        busy_o = 1'b0;
    end
    // long frames overrun the timeout on purpose; short ones keep it
    always @(posedge sys_clk_i) begin
        crc_ok_o <= 1'b0;
        if (start_i && !busy_o) begin
            busy_o <= 1'b1;
            chip_sel_n_o <= 1'b0;
            cnt_q <= len_i;
        end else if (busy_o && cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
            bit_valid_o <= cnt_q[0];
        end else if (busy_o) begin
            chip_sel_n_o <= 1'b1;
            bit_valid_o <= 1'b0;
            busy_o <= 1'b0;
            crc_ok_o <= 1'b1;
        end
    end
endmodule

/* tb/test_device_monitor_config.sv */
// self-checking bench for the monitor configuration block
module test_device_monitor_config
    import dmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, tick, start, cs_n, bit_v, crc_ok, busy, src2, fmt2, src0;
    logic        rvalid, map_hit, accept, tmo, pin2, oe2, loss, loss_oe, seen_tmo, seen_acc;
    logic [15:0] len, step15, status, mask, rdata;
    dmc_req_type req;
    dmc_cfg_type cfg;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    // write value beside expected read-back
    logic [15:0] rows [4][2] = '{'{16'hFFFF, 16'hF107}, '{16'h5A5A, 16'h5002},
                                 '{16'hA0A5, 16'hA005}, '{16'h0000, 16'h0000}};
    dmc_monitor_config #(.TIMEOUT_EXP(4)) dut_u (
        .sys_clk_i(clk), .rst_n_i(rst_n), .osc_tick_i(tick), .chip_sel_n_i(cs_n),
        .serial_bit_valid_i(bit_v), .cmd_crc_ok_i(crc_ok), .req_i(req),
        .step15_result_value_i(step15), .status_i(status), .status_mask_i(mask),
        .pin_two_source_select_i(src2), .pin_two_drive_format_i(fmt2),
        .pin_zero_source_select_i(src0), .rdata_o(rdata), .rvalid_o(rvalid), .cfg_o(cfg),
        .map_check_addr_o(map_hit), .serial_bit_accept_o(accept), .frame_timeout_o(tmo),
        .pin_two_o(pin2), .pin_two_oe_o(oe2), .host_loss_output_o(loss),
        .host_loss_oe_o(loss_oe));
    dmc_host_model host_u (.sys_clk_i(clk), .start_i(start), .len_i(len),
        .chip_sel_n_o(cs_n), .bit_valid_o(bit_v), .crc_ok_o(crc_ok), .busy_o(busy));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // oscillator tick every second cycle; sticky frame flags; hang guard
    always @(negedge clk) tick <= ~tick;
    always @(posedge clk) begin
        seen_tmo <= seen_tmo | tmo;
        seen_acc <= seen_acc | accept;
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            check(16'h0000, 16'h0001, "timeout");
            print_verdict();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
    endtask
    task automatic reg_rd(input logic [6:0] a, input logic [15:0] e);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clk);
        req = '0;
        check(rvalid, 1'b1, "read valid");
        check(rdata, e, "read data");
    endtask
    // one host frame, flags cleared first
    task automatic frame(input logic [15:0] n);
        @(negedge clk);
        seen_tmo = 1'b0;
        seen_acc = 1'b0;
        len = n;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (int i = 0; i < 300 && busy; i++) @(negedge clk);
        idle(4);
    endtask
    task automatic fault(input logic [15:0] w, st, mk, input logic f, ep, eo);
        reg_wr(7'h40, w);
        status = st;
        mask = mk;
        fmt2 = f;
        idle(2);
        if (!f) check(pin2, ep, "fault level");
        check(oe2, eo, "fault enable");
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        {rst_n, tick, start, fmt2, seen_tmo, seen_acc} = '0;
        {len, status, mask} = '0;
        {src2, src0} = 2'h3;
        step15 = 16'h8001;
        req = '0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        reg_rd(7'h40, 16'h0000);
        reg_rd(7'h41, 16'h0000);
        reg_wr(7'h1F, 16'h1234);
        reg_rd(7'h1F, 16'h8001);
        foreach (rows[i]) begin
            reg_wr(7'h40, rows[i][0]);
            reg_rd(7'h40, rows[i][1]);
            check({8'h00, cfg}, {8'h00, rows[i][1][15:12], rows[i][1][8], rows[i][1][2:0]}, "cfg");
        end
        reg_wr(7'h40, 16'h8000);
        idle(1);
        req.addr = 7'h3F;
        idle(1);
        check(map_hit, 1'b0, "below section");
        req.addr = 7'h59;
        idle(1);
        check(map_hit, 1'b1, "section top");
        req.addr = 7'h5A;
        idle(1);
        check(map_hit, 1'b0, "past section");
        req = '0;
        frame(16'd80);
        check(seen_tmo, 1'b0, "timeout while off");
        reg_wr(7'h40, 16'h1000);
        frame(16'd20);
        frame(16'd20);
        check(seen_tmo, 1'b0, "counter not restarted");
        frame(16'd80);
        check(seen_tmo, 1'b1, "no timeout");
        check(tmo, 1'b0, "discard after rise");
        frame(16'd20);
        check(seen_acc, 1'b1, "new frame ignored");
        fault(16'h0000, 16'h0080, 16'h0000, 1'b0, 1'b0, 1'b1);
        fault(16'h0000, 16'h4000, 16'h4000, 1'b0, 1'b1, 1'b1);
        fault(16'h0000, 16'h0040, 16'h0000, 1'b0, 1'b1, 1'b1);
        fault(16'h0100, 16'h4000, 16'h0000, 1'b0, 1'b1, 1'b1);
        fault(16'h0100, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b1);
        fault(16'h0000, 16'h0100, 16'h0000, 1'b1, 1'b0, 1'b1);
        fault(16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0);
        src2 = 1'b0;
        fault(16'h0000, 16'h0080, 16'h0000, 1'b0, 1'b0, 1'b0);
        src2 = 1'b1;
        reg_wr(7'h40, 16'h0001);
        frame(16'd4);
        idle(10000);
        check(loss, 1'b1, "loss too early");
        idle(400);
        check(loss, 1'b0, "loss missing");
        check(loss_oe, 1'b1, "loss enable");
        src0 = 1'b0;
        idle(2);
        check(loss_oe, 1'b0, "loss pin not routed");
        src0 = 1'b1;
        reg_wr(7'h40, 16'h0000);
        idle(3);
        check(loss, 1'b1, "loss not released");
        reg_wr(7'h40, 16'h0006);
        idle(15000);
        frame(16'd4);
        idle(15000);
        check(loss, 1'b0, "watchdog not restarted");
        idle(6000);
        check(loss, 1'b1, "active high loss");
        reg_wr(7'h40, 16'h0000);
        reg_wr(7'h40, 16'h0007);
        idle(21000);
        check(loss, 1'b0, "longest window too short");
        rst_n = 1'b0;
        idle(3);
        rst_n = 1'b1;
        reg_rd(7'h40, 16'h0000);
        print_verdict();
    end
endmodule
